// *** core/sca_auth.sv ***
// Challenge-response hash authentication engine behind the serial bus
// Functional notes
// - Block holds secret, challenge, constant fill
// - Identifier variant inserts serial identifier
// - Only digest leaves; secret never output
// - Block is sixteen words, first schedule
// - Block built at compute; secret hash-only
// - Challenge cleared by compute; host rewrites
// - Working variables start at chaining constants
// - Chaining constants added after final round
// - Digest shifted out, LSB of A first
// - Eighty rounds, one schedule word each
// - All additions wrap modulo two to 32
// - Shift is a 32-bit left rotation
// - Exactly one of four modes at once
// - Compute mode only from communication mode
// - Thermistor command disconnects bus, pulls pin
// - Thermistor held until holdup supply collapses
// - Bus reaches the hash; serial identifier only enters the block
// - Round temp word sums rotation, function, constants
// - Non-identifier variants fill identifier with ones
// - Write challenge takes eight bytes only
`timescale 1ns/10ps
module sca_auth (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Received command and data bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  // Read slot request and answered bit
  input wire logic rd_req,
  output logic rd_bit,
  output logic rd_valid,
  // Nonvolatile secret and serial identifier
  input wire logic [63:0] stored_secret,
  input wire logic [63:0] unique_serial_id,
  // Supply and programming detectors
  input wire logic hv_detect,
  input wire logic holdup_collapse,
  // Mode and pin control
  output sca_pkg::sca_mode_t mode,
  output logic bus_disconnect,
  output logic thermistor_mux_pin_out,
  output logic thermistor_mux_pin_oe_n,
  output logic digest_ready
);

  // ---------------------------------------------------------------
  // Hash helpers
  // ---------------------------------------------------------------
  // left rotation
  // Callers pass 1, 5 and 30 only, so no shift is ever 32 wide
  function automatic logic [31:0] rotl(input logic [31:0] x, input int n);
    rotl = (x << n) | (x >> (32 - n));
  endfunction

  function automatic logic [31:0] round_fn(input logic [6:0] t, input sca_pkg::sca_vars_t v);
    if (t < sca_pkg::GROUP1_START) begin
      round_fn = (v.b & v.c) | (~v.b & v.d);
    end else if (t < sca_pkg::GROUP2_START) begin
      round_fn = v.b ^ v.c ^ v.d;
    end else if (t < sca_pkg::GROUP3_START) begin
      round_fn = (v.b & v.c) | (v.b & v.d) | (v.c & v.d);
    end else begin
      round_fn = v.b ^ v.c ^ v.d;
    end
  endfunction

  function automatic logic [31:0] round_const(input logic [6:0] t);
    if (t < sca_pkg::GROUP1_START) begin
      round_const = sca_pkg::K0;
    end else if (t < sca_pkg::GROUP2_START) begin
      round_const = sca_pkg::K1;
    end else if (t < sca_pkg::GROUP3_START) begin
      round_const = sca_pkg::K2;
    end else begin
      round_const = sca_pkg::K3;
    end
  endfunction

  function automatic logic is_compute(input logic [7:0] op);
    is_compute = (op == sca_pkg::CMD_MAC_WITH_ID) || (op == sca_pkg::CMD_MAC_NO_ID) ||
                 (op == sca_pkg::CMD_NEXT_WITH_ID) || (op == sca_pkg::CMD_NEXT_NO_ID);
  endfunction

  function automatic logic is_prog(input logic [7:0] op);
    is_prog = (op == sca_pkg::CMD_LOAD_SECRET) || (op == sca_pkg::CMD_LOCK_SECRET) ||
              (op == sca_pkg::CMD_SET_FAST) || (op == sca_pkg::CMD_CLEAR_FAST) ||
              (op == sca_pkg::CMD_NEXT_WITH_ID) || (op == sca_pkg::CMD_NEXT_NO_ID);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // Sliding sixteen-word window; slot 0 always holds this round's word
  logic [31:0] sched [16];
  logic [31:0] next_sched [16];
  sca_pkg::sca_vars_t vars, next_vars;
  logic [6:0] round_idx, next_round_idx;
  logic [63:0] challenge, next_challenge;
  logic chal_active, next_chal_active;
  logic [2:0] chal_count, next_chal_count;
  logic prog_armed, next_prog_armed;
  logic [159:0] out_shift, next_out_shift;
  logic [7:0] bits_left, next_bits_left;
  sca_pkg::sca_mode_t next_mode;
  logic next_rd_bit, next_rd_valid, next_digest_ready;
  logic next_bus_disconnect, next_mux_oe_n;
  logic [31:0] round_temp_word, new_word;
  logic [63:0] id_field;

  // Round datapath; every sum wraps since the target is 32 bits
  always_comb begin
    // carry out of bit 31 dropped
    round_temp_word = rotl(vars.a, 5) + round_fn(round_idx, vars) + sched[0] +
                      round_const(round_idx) + vars.e;
    new_word = rotl(sched[13] ^ sched[8] ^ sched[2] ^ sched[0], 1);
    id_field = (rx_byte == sca_pkg::CMD_MAC_WITH_ID || rx_byte == sca_pkg::CMD_NEXT_WITH_ID) ?
               unique_serial_id : sca_pkg::ID_ONES;
  end

  // Next-state logic for mode, parser, hash and read-out
  always_comb begin
    next_mode = mode;
    next_vars = vars;
    next_round_idx = round_idx;
    next_challenge = challenge;
    next_chal_active = chal_active;
    next_chal_count = chal_count;
    next_prog_armed = prog_armed;
    next_out_shift = out_shift;
    next_bits_left = bits_left;
    next_rd_bit = rd_bit;
    next_rd_valid = 1'b0;
    next_digest_ready = digest_ready;
    next_bus_disconnect = bus_disconnect;
    next_mux_oe_n = thermistor_mux_pin_oe_n;
    for (int i = 0; i < 16; i++) begin
      next_sched[i] = sched[i];
    end
    case (mode)
      sca_pkg::SCA_COMM: begin
        if (rx_valid && chal_active) begin
          // eight bytes, later bytes are parsed as commands
          next_challenge[8 * chal_count +: 8] = rx_byte;
          next_chal_count = chal_count + 3'h1;
          next_chal_active = (chal_count != sca_pkg::CHAL_LAST_BYTE);
        end else if (rx_valid) begin
          // Any other byte disarms, so a pulse only follows its own command
          next_prog_armed = is_prog(rx_byte);
          if (rx_byte == sca_pkg::CMD_WRITE_CHALLENGE) begin
            next_chal_active = 1'b1;
            next_chal_count = 3'h0;
          end else if (is_compute(rx_byte)) begin
            next_sched[sca_pkg::WORD_SECRET] = stored_secret[63:32];
            next_sched[sca_pkg::WORD_SECRET + 1] = stored_secret[31:0];
            next_sched[sca_pkg::WORD_CHALLENGE] = challenge[63:32];
            next_sched[sca_pkg::WORD_CHALLENGE + 1] = challenge[31:0];
            next_sched[sca_pkg::WORD_SERIAL] = id_field[63:32];
            next_sched[sca_pkg::WORD_SERIAL + 1] = id_field[31:0];
            for (int i = sca_pkg::WORD_CONST; i < 15; i++) begin
              next_sched[i] = (i == sca_pkg::WORD_CONST) ? sca_pkg::FILL_WORD : 32'h00000000;
            end
            next_sched[15] = sca_pkg::LEN_WORD;
            next_vars = '{sca_pkg::H0, sca_pkg::H1, sca_pkg::H2, sca_pkg::H3, sca_pkg::H4};
            next_round_idx = 7'h00;
            next_digest_ready = 1'b0;
            next_mode = sca_pkg::SCA_COMPUTE;
          end else if (rx_byte == sca_pkg::CMD_THERMISTOR) begin
            next_bus_disconnect = 1'b1;
            next_mux_oe_n = 1'b0;
            next_mode = sca_pkg::SCA_THERM;
          end
        end else if (hv_detect && prog_armed) begin
          next_mode = sca_pkg::SCA_PROGRAM;
        end
        // LSB of A first, one bit per read slot
        // only the digest is ever shifted out
        if (rd_req && digest_ready) begin
          next_rd_bit = out_shift[0];
          next_rd_valid = 1'b1;
          next_out_shift = {1'b0, out_shift[159:1]};
          next_bits_left = bits_left - 8'h01;
          next_digest_ready = (bits_left != 8'h01);
        end
      end
      sca_pkg::SCA_COMPUTE: begin
        // Bytes and read slots are dropped while the rounds run
        // stale challenge cannot be reused
        next_challenge = 64'h0000000000000000;
        next_chal_active = 1'b0;
        // one round per cycle over 0..79
        next_vars = '{round_temp_word, vars.a, rotl(vars.b, 30), vars.c, vars.d};
        for (int i = 0; i < 15; i++) begin
          next_sched[i] = sched[i + 1];
        end
        next_sched[15] = new_word;
        next_round_idx = round_idx + 7'h01;
        if (round_idx == sca_pkg::ROUND_LAST) begin
          // add chaining constants to final round
          next_vars.a = round_temp_word + sca_pkg::H0;
          next_vars.b = vars.a + sca_pkg::H1;
          next_vars.c = rotl(vars.b, 30) + sca_pkg::H2;
          next_vars.d = vars.c + sca_pkg::H3;
          next_vars.e = vars.d + sca_pkg::H4;
          next_out_shift = {next_vars.e, next_vars.d, next_vars.c, next_vars.b, next_vars.a};
          next_bits_left = sca_pkg::DIGEST_BITS;
          next_digest_ready = 1'b1;
          next_mode = sca_pkg::SCA_COMM;
        end
      end
      sca_pkg::SCA_PROGRAM: begin
        // Held for the whole pulse; the array write is outside this block
        if (!hv_detect) begin
          next_prog_armed = 1'b0;
          next_mode = sca_pkg::SCA_COMM;
        end
      end
      sca_pkg::SCA_THERM: begin
        // only supply collapse leaves, as a power cycle
        if (holdup_collapse) begin
          // Leave the mode, pin, challenge and flag state that a fresh power-up would leave
          next_bus_disconnect = 1'b0;
          next_mux_oe_n = 1'b1;
          next_challenge = 64'h0000000000000000;
          next_chal_active = 1'b0;
          next_prog_armed = 1'b0;
          next_digest_ready = 1'b0;
          next_mode = sca_pkg::SCA_COMM;
        end
      end
      // Unused encoding falls back to idle communication
      default: begin
        next_mode = sca_pkg::SCA_COMM;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Secret sits only in the schedule; never routed to the read path
  // Reset branch loads constants only; no input reaches it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode <= sca_pkg::SCA_COMM;
      vars <= '0;
      round_idx <= 7'h00;
      challenge <= 64'h0000000000000000;
      chal_active <= 1'b0;
      chal_count <= 3'h0;
      prog_armed <= 1'b0;
      out_shift <= '0;
      bits_left <= 8'h00;
      rd_bit <= 1'b0;
      rd_valid <= 1'b0;
      digest_ready <= 1'b0;
      bus_disconnect <= 1'b0;
      thermistor_mux_pin_oe_n <= 1'b1;
      thermistor_mux_pin_out <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        sched[i] <= 32'h00000000;
      end
    end else begin
      mode <= next_mode;
      vars <= next_vars;
      round_idx <= next_round_idx;
      challenge <= next_challenge;
      chal_active <= next_chal_active;
      chal_count <= next_chal_count;
      prog_armed <= next_prog_armed;
      out_shift <= next_out_shift;
      bits_left <= next_bits_left;
      rd_bit <= next_rd_bit;
      rd_valid <= next_rd_valid;
      digest_ready <= next_digest_ready;
      bus_disconnect <= next_bus_disconnect;
      thermistor_mux_pin_oe_n <= next_mux_oe_n;
      thermistor_mux_pin_out <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        sched[i] <= next_sched[i];
      end
    end
  end

endmodule

// *** core/sca_pkg.sv ***
// Constants and types shared by the challenge-response hash engine
package sca_pkg;

  // ---------------------------------------------------------------
  // Command opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_CHALLENGE = 8'h0C;
  localparam logic [7:0] CMD_MAC_WITH_ID = 8'h35;
  localparam logic [7:0] CMD_MAC_NO_ID = 8'h36;
  localparam logic [7:0] CMD_NEXT_WITH_ID = 8'h33;
  localparam logic [7:0] CMD_NEXT_NO_ID = 8'h30;
  localparam logic [7:0] CMD_LOAD_SECRET = 8'h5A;
  localparam logic [7:0] CMD_LOCK_SECRET = 8'h6A;
  localparam logic [7:0] CMD_SET_FAST = 8'h8B;
  localparam logic [7:0] CMD_CLEAR_FAST = 8'h8D;
  localparam logic [7:0] CMD_THERMISTOR = 8'hA5;

  // ---------------------------------------------------------------
  // Hash constants
  // ---------------------------------------------------------------
  localparam logic [31:0] H0 = 32'h67452301;
  localparam logic [31:0] H1 = 32'hEFCDAB89;
  localparam logic [31:0] H2 = 32'h98BADCFE;
  localparam logic [31:0] H3 = 32'h10325476;
  localparam logic [31:0] H4 = 32'hC3D2E1F0;
  localparam logic [31:0] K0 = 32'h5A827999;
  localparam logic [31:0] K1 = 32'h6ED9EBA1;
  localparam logic [31:0] K2 = 32'h8F1BBCDC;
  localparam logic [31:0] K3 = 32'hCA62C1D6;
  localparam logic [6:0] ROUND_LAST = 7'h4F;
  localparam logic [6:0] GROUP1_START = 7'h14;
  localparam logic [6:0] GROUP2_START = 7'h28;
  localparam logic [6:0] GROUP3_START = 7'h3C;

  // ---------------------------------------------------------------
  // Message block layout, word index within W0..W15
  // ---------------------------------------------------------------
  localparam int WORD_SECRET = 0;
  localparam int WORD_CHALLENGE = 2;
  localparam int WORD_SERIAL = 4;
  localparam int WORD_CONST = 6;
  localparam logic [31:0] FILL_WORD = 32'h80000000;
  localparam logic [31:0] LEN_WORD = 32'h00000180;
  localparam logic [63:0] ID_ONES = 64'hFFFFFFFFFFFFFFFF;

  // ---------------------------------------------------------------
  // Counts
  // ---------------------------------------------------------------
  localparam logic [2:0] CHAL_LAST_BYTE = 3'h7;
  localparam logic [7:0] DIGEST_BITS = 8'hA0;

  // Operating modes, Gray coded
  typedef enum logic [1:0] {
    SCA_COMM = 2'b00,
    SCA_COMPUTE = 2'b01,
    SCA_PROGRAM = 2'b11,
    SCA_THERM = 2'b10
  } sca_mode_t;

  // Five working variables travel together
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] d;
    logic [31:0] e;
  } sca_vars_t;

endpackage

// *** dv/sca_auth_properties.sv ***
// Port-level timing checks for the hash engine
`timescale 1ns/10ps
module sca_auth_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Byte and read ports
  input wire logic rx_valid,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic holdup_collapse,
  // Mode and pins
  input wire sca_pkg::sca_mode_t mode,
  input wire logic bus_disconnect,
  input wire logic thermistor_mux_pin_out,
  input wire logic thermistor_mux_pin_oe_n,
  input wire logic digest_ready
);
  // -------------------------------------------------------------
  // Round counter
  // -------------------------------------------------------------
  logic [6:0] cycles_in;
  logic [6:0] next_cycles_in;
  logic rd_ok;
  assign rd_ok = rd_req && mode == sca_pkg::SCA_COMM && digest_ready;
  // Cycles already spent in this compute run
  always_comb begin
    next_cycles_in = 7'h00;
    if (mode == sca_pkg::SCA_COMPUTE) next_cycles_in = cycles_in + 7'h01;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) cycles_in <= 7'h00;
    else cycles_in <= next_cycles_in;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_last_round;
    mode == sca_pkg::SCA_COMPUTE && cycles_in == 7'h4F;
  endsequence
  sequence s_in_round;
    mode == sca_pkg::SCA_COMPUTE && cycles_in != 7'h4F;
  endsequence
  a_compute_hold: assert property (s_in_round |=> mode == sca_pkg::SCA_COMPUTE)
    else $error("compute ended early");
  a_compute_done: assert property (s_last_round |=> mode == sca_pkg::SCA_COMM && digest_ready)
    else $error("compute not done after 80 cycles");
  a_compute_entry: assert property (mode == sca_pkg::SCA_COMPUTE && $past(mode) != mode
    |-> $past(mode) == sca_pkg::SCA_COMM && $past(rx_valid)) else $error("bad compute entry");
  a_read_answer: assert property (rd_ok |=> rd_valid)
    else $error("read slot unanswered");
  a_read_idle: assert property (!rd_ok |=> !rd_valid)
    else $error("read answer without accepted slot");
  a_therm_pins: assert property (bus_disconnect == (mode == sca_pkg::SCA_THERM)
    && thermistor_mux_pin_oe_n == !bus_disconnect) else $error("pin control off mode");
  a_pin_low: assert property (thermistor_mux_pin_out == 1'b0)
    else $error("pin driven high");
  a_therm_stay: assert property (mode == sca_pkg::SCA_THERM && !holdup_collapse
    |=> mode == sca_pkg::SCA_THERM) else $error("left thermistor mode early");
  a_therm_exit: assert property (mode == sca_pkg::SCA_THERM && holdup_collapse
    |=> mode == sca_pkg::SCA_COMM) else $error("no return after collapse");
endmodule
bind sca_auth sca_auth_properties chk (.clock, .rst, .rx_valid, .rd_req, .rd_valid,
  .holdup_collapse, .mode, .bus_disconnect, .thermistor_mux_pin_out,
  .thermistor_mux_pin_oe_n, .digest_ready);

// *** dv/sca_host_model.sv ***
// Behavioural host that sends bytes and read slots to the engine
`timescale 1ns/10ps
module sca_host_model (
  // Clock
  input wire logic clock,
  // Byte and read slot requests
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rd_req,
  // Answered bit
  input wire logic rd_bit,
  input wire logic rd_valid
);
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rd_req = 1'b0;
  end
  task automatic send_byte(input logic [7:0] b);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_byte <= ~b;  // Released byte never shows the stale value
  endtask
  task automatic authenticate(input logic [63:0] chal, input logic [7:0] op, input bit wr);
    if (wr) begin
      send_byte(sca_pkg::CMD_WRITE_CHALLENGE);
      for (int k = 0; k < 8; k++) send_byte(chal[8*k +: 8]);
    end
    send_byte(op);
  endtask
  // One read slot; answer lands one cycle after the request edge
  task automatic read_bit(output logic b, output logic v);
    @(posedge clock);
    rd_req <= 1'b1;
    @(posedge clock);
    rd_req <= 1'b0;
    #1;
    v = rd_valid;
    b = rd_bit;
  endtask
  // one zero byte, then 160 reads
  task automatic collect(output logic [159:0] bits, output int nv);
    logic b;
    logic v;
    nv = 0;
    send_byte(8'h00);
    for (int i = 0; i < 160; i++) begin
      if (i % 7 == 3) @(posedge clock);  // Slow host now and then
      read_bit(b, v);
      bits[i] = b;
      nv += int'(v);
    end
  endtask
endmodule

// *** dv/sca_auth_tb_top.sv ***
// Self-checking bench for the challenge-response hash engine
`timescale 1ns/10ps
module sca_auth_tb_top;
  logic clock, rst, rx_valid, rd_req, rd_bit, rd_valid, hv_detect, holdup_collapse;
  logic bus_disconnect, pin_out, pin_oe_n, digest_ready;
  logic [7:0] rx_byte;
  logic [63:0] stored_secret, unique_serial_id, chal;
  logic [159:0] bits;
  logic [31:0] rng;
  logic [7:0] ops [5] = '{8'h35, 8'h36, 8'h33, 8'h30, 8'h36};
  logic [7:0] prog_ops [4] = '{sca_pkg::CMD_LOAD_SECRET, sca_pkg::CMD_LOCK_SECRET,
    sca_pkg::CMD_SET_FAST, sca_pkg::CMD_CLEAR_FAST};
  sca_pkg::sca_mode_t mode;
  int fails, samples_checked;
  sca_host_model host (.clock, .rx_valid, .rx_byte, .rd_req, .rd_bit, .rd_valid);
  sca_auth dut (.clock, .rst, .rx_valid, .rx_byte, .rd_req, .rd_bit, .rd_valid,
    .stored_secret, .unique_serial_id, .hv_detect, .holdup_collapse, .mode, .bus_disconnect,
    .thermistor_mux_pin_out(pin_out), .thermistor_mux_pin_oe_n(pin_oe_n), .digest_ready);
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic rnd64(output logic [63:0] v);
    rng = xs(rng);
    v[63:32] = rng;
    rng = xs(rng);
    v[31:0] = rng;
  endtask
  // Reference digest of one block, plain arithmetic wraps at 32 bits
  function automatic logic [159:0] sha1(input logic [511:0] blk);
    logic [31:0] w [80];
    logic [31:0] a, b, c, d, e, f, k, t;
    for (int i = 0; i < 16; i++) w[i] = blk[511-32*i -: 32];
    for (int i = 16; i < 80; i++) begin
      t = w[i-3] ^ w[i-8] ^ w[i-14] ^ w[i-16];
      w[i] = {t[30:0], t[31]};
    end
    {a, b, c, d, e} = {sca_pkg::H0, sca_pkg::H1, sca_pkg::H2, sca_pkg::H3, sca_pkg::H4};
    for (int i = 0; i < 80; i++) begin
      f = (i < 20) ? ((b & c) | (~b & d)) : (i >= 40 && i < 60) ? ((b & c) | (b & d) | (c & d))
        : (b ^ c ^ d);
      k = (i < 20) ? 32'h5A827999 : (i < 40) ? 32'h6ED9EBA1 : (i < 60) ? 32'h8F1BBCDC
        : 32'hCA62C1D6;
      t = {a[26:0], a[31:27]} + f + w[i] + k + e;
      {e, d, c, b, a} = {d, c, {b[1:0], b[31:2]}, a, t};
    end
    return {a + sca_pkg::H0, b + sca_pkg::H1, c + sca_pkg::H2, d + sca_pkg::H3, e + sca_pkg::H4};
  endfunction
  task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One authentication, stray byte mid-compute, full digest readout
  task automatic run_auth(input logic [7:0] op, input bit wr);
    logic [159:0] exp, ord;
    logic [63:0] sec, idf;
    logic b, v;
    int nv, n;
    rnd64(sec);
    rnd64(chal);
    @(posedge clock);
    stored_secret <= sec;
    idf = (op == 8'h35 || op == 8'h33) ? unique_serial_id : sca_pkg::ID_ONES;
    exp = sha1({sec, wr ? chal : 64'h0, idf, sca_pkg::FILL_WORD, 256'h0, sca_pkg::LEN_WORD});
    for (int i = 0; i < 160; i++) ord[i] = exp[128 - 32*(i/32) + i%32];
    host.authenticate(chal, op, wr);
    #1;
    check(160'(mode), 160'(sca_pkg::SCA_COMPUTE));
    n = 0;
    fork
      host.send_byte(sca_pkg::CMD_THERMISTOR);
    join_none
    while (mode == sca_pkg::SCA_COMPUTE && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(160'(n), 160'h50);
    check(160'({mode, digest_ready}), 160'({sca_pkg::SCA_COMM, 1'b1}));
    host.collect(bits, nv);
    check(bits, ord);
    check(160'(nv), 160'hA0);
    check(160'(digest_ready), 160'h0);
    host.read_bit(b, v);
    check(160'(v), 160'h0);
  endtask
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    {rst, hv_detect, holdup_collapse} = 3'b100;
    {stored_secret, unique_serial_id} = 128'h0;
    {fails, samples_checked} = 64'h0;
    rng = 32'hF0CB0857;
    repeat (10) @(posedge clock);
    rnd64(chal);
    unique_serial_id <= chal;
    rst <= 1'b0;
    #1;
    check(160'({mode, pin_oe_n, digest_ready}), 160'({sca_pkg::SCA_COMM, 2'b10}));
    // Last run skips the challenge write, so a zero challenge is expected
    for (int i = 0; i < 5; i++) run_auth(ops[i], i < 4);
    host.send_byte(sca_pkg::CMD_THERMISTOR);
    #1;
    check(160'({mode, bus_disconnect, pin_oe_n, pin_out}), 160'({sca_pkg::SCA_THERM, 3'b100}));
    host.send_byte(sca_pkg::CMD_WRITE_CHALLENGE);
    repeat (5) @(posedge clock);
    holdup_collapse <= 1'b1;
    #1;
    check(160'(mode), 160'(sca_pkg::SCA_THERM));
    @(posedge clock);
    holdup_collapse <= 1'b0;
    #1;
    check(160'({mode, bus_disconnect, digest_ready}), 160'({sca_pkg::SCA_COMM, 2'b00}));
    // programming pulse after each of the four load, lock and fast commands
    foreach (prog_ops[j]) begin
      host.send_byte(prog_ops[j]);
      @(posedge clock);
      hv_detect <= 1'b1;
      @(posedge clock);
      #1;
      check(160'(mode), 160'(sca_pkg::SCA_PROGRAM));
      @(posedge clock);
      hv_detect <= 1'b0;
      @(posedge clock);
      #1;
      check(160'(mode), 160'(sca_pkg::SCA_COMM));
    end
    // A pulse after a plain byte must not enter programming
    host.send_byte(8'h00);
    hv_detect <= 1'b1;
    repeat (2) @(posedge clock);
    hv_detect <= 1'b0;
    #1;
    check(160'(mode), 160'(sca_pkg::SCA_COMM));
    tally_and_finish;
  end
  // Cut a hang short well beyond the few thousand cycles needed
  initial begin
    repeat (30000) @(posedge clock);
    fails++;
    tally_and_finish;
  end
endmodule
